// ==== verilog/rbbo_core.v ====
`timescale 1ns/1ns
`include "rbbo_defines.vh"

module rbbo_core
#(
	parameter PC_W = 21
)
(
	mclk,
	sys_rst,
	instr_word,
	next_two_word,
	bank_select_pointer,
	ext_instr_en,
	index_base,
	dmem_rdata,
	q_phase,
	pc,
	pc_load,
	discard_fetch,
	exec_nop,
	decode_hit,
	dmem_addr,
	dmem_rd_en,
	dmem_wr_en,
	dmem_wdata
);
	input wire mclk;
	input wire sys_rst;
	input wire [15:0] instr_word;
	input wire next_two_word;
	input wire [3:0] bank_select_pointer;
	input wire ext_instr_en;
	input wire [11:0] index_base;
	input wire [7:0] dmem_rdata;
	output wire [1:0] q_phase;
	output wire [PC_W-1:0] pc;
	output wire pc_load;
	output wire discard_fetch;
	output wire exec_nop;
	output wire decode_hit;
	output wire [11:0] dmem_addr;
	output wire dmem_rd_en;
	output wire dmem_wr_en;
	output wire [7:0] dmem_wdata;

	localparam OP_NONE = 3'h0;
	localparam OP_JUMP = 3'h1;
	localparam OP_BSET = 3'h2;
	localparam OP_SKIPCLR = 3'h3;
	localparam OP_SKIPSET = 3'h4;
	localparam OP_NOP = 3'h5;

	// ********************************
	// decode
	// ********************************
	function [2:0] rbbo_decode;
		input [15:0] word;
		begin
			case (word[`RBBO_OPC_HI:`RBBO_OPC_LO])
				`RBBO_OPC_JUMP:
					rbbo_decode = word[`RBBO_JUMP_ZBIT] ? OP_NONE : OP_JUMP;
				`RBBO_OPC_BSET:
					rbbo_decode = OP_BSET;
				`RBBO_OPC_SKIPCLR:
					rbbo_decode = OP_SKIPCLR;
				`RBBO_OPC_SKIPSET:
					rbbo_decode = OP_SKIPSET;
				default:
					rbbo_decode = OP_NONE;
			endcase
		end
	endfunction

	reg [1:0] q_reg;
	reg [1:0] q_next;
	reg [2:0] op_reg;
	reg [2:0] op_next;
	reg [15:0] word_reg;
	reg [15:0] word_next;
	reg [1:0] nop_cnt_reg;
	reg [1:0] nop_cnt_next;
	reg [PC_W-1:0] pc_reg;
	reg [PC_W-1:0] pc_next;
	reg pc_load_reg;
	reg pc_load_next;
	reg discard_reg;
	reg discard_next;
	reg [7:0] data_reg;
	reg [7:0] data_next;
	reg [11:0] addr_reg;
	reg [11:0] addr_next;
	reg rd_en_reg;
	reg rd_en_next;
	reg wr_en_reg;
	reg wr_en_next;
	reg [7:0] wdata_reg;
	reg [7:0] wdata_next;

	wire [11:0] ea;
	wire [7:0] bit_mask;
	wire tested_bit;
	wire [11:0] jump_off2;
	wire [PC_W-1:0] jump_ext;

	rbbo_bank_addr u_bank_addr
	(
		.file_addr(word_reg[`RBBO_FILE_HI:`RBBO_FILE_LO]),
		.access_bit(word_reg[`RBBO_ACC_BIT]),
		.bank_select_pointer(bank_select_pointer),
		.ext_instr_en(ext_instr_en),
		.index_base(index_base),
		.data_addr(ea),
		.indexed_mode()
	);

	assign bit_mask = 8'h01 << word_reg[`RBBO_BIT_HI:`RBBO_BIT_LO];
	assign tested_bit = |(data_reg & bit_mask);
	// offset doubled, sign kept; reach is -1024..1023 words
	assign jump_off2 = {word_reg[`RBBO_JUMP_OFF_HI:0], 1'b0};
	assign jump_ext = {{(PC_W-12){jump_off2[11]}}, jump_off2};

	// ********************************
	// phase sequencing
	// ********************************
	always @*
	begin
		q_next = q_reg + 2'h1;
		op_next = op_reg;
		word_next = word_reg;
		nop_cnt_next = nop_cnt_reg;
		pc_next = pc_reg;
		pc_load_next = 1'b0;
		discard_next = 1'b0;
		data_next = data_reg;
		addr_next = addr_reg;
		rd_en_next = 1'b0;
		wr_en_next = 1'b0;
		wdata_next = wdata_reg;
		case (q_reg)
			`RBBO_Q1:
			begin
				// fetch pointer moves on every cycle, nop or not
				pc_next = pc_reg + {{(PC_W-2){1'b0}}, `RBBO_PC_STEP};
				if (nop_cnt_reg != `RBBO_NOP_NONE)
				begin
					// the fetched word is thrown away, not decoded
					op_next = OP_NOP;
					nop_cnt_next = nop_cnt_reg - 2'h1;
				end
				else
				begin
					op_next = rbbo_decode(instr_word);
					word_next = instr_word;
				end
			end
			`RBBO_Q2:
			begin
				if (op_reg == OP_BSET || op_reg == OP_SKIPCLR || op_reg == OP_SKIPSET)
				begin
					addr_next = ea;
					rd_en_next = 1'b1;
				end
			end
			`RBBO_Q3:
			begin
				if (op_reg == OP_BSET || op_reg == OP_SKIPCLR || op_reg == OP_SKIPSET)
					data_next = dmem_rdata;
			end
			`RBBO_Q4:
			begin
				case (op_reg)
					OP_JUMP:
					begin
						// pc already holds the incremented address
						pc_next = pc_reg + jump_ext;
						pc_load_next = 1'b1;
						discard_next = 1'b1;
						nop_cnt_next = `RBBO_SKIP_ONE;
					end
					OP_BSET:
					begin
						wr_en_next = 1'b1;
						wdata_next = data_reg | bit_mask;
					end
					OP_SKIPCLR, OP_SKIPSET:
					begin
						if (tested_bit == (op_reg == OP_SKIPSET))
						begin
							discard_next = 1'b1;
							nop_cnt_next = next_two_word ? `RBBO_SKIP_TWO : `RBBO_SKIP_ONE;
						end
					end
					default:
					begin
						nop_cnt_next = nop_cnt_reg;
					end
				endcase
			end
			default:
			begin
				q_next = `RBBO_Q1;
			end
		endcase
	end

	// ********************************
	// state registers
	// ********************************
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			q_reg <= `RBBO_Q1;
			op_reg <= OP_NONE;
			word_reg <= 16'h0000;
			nop_cnt_reg <= `RBBO_NOP_NONE;
			pc_reg <= {{(PC_W-16){1'b0}}, `RBBO_PC_RESET};
			pc_load_reg <= 1'b0;
			discard_reg <= 1'b0;
			data_reg <= 8'h00;
			addr_reg <= 12'h000;
			rd_en_reg <= 1'b0;
			wr_en_reg <= 1'b0;
			wdata_reg <= 8'h00;
		end
		else
		begin
			q_reg <= q_next;
			op_reg <= op_next;
			word_reg <= word_next;
			nop_cnt_reg <= nop_cnt_next;
			pc_reg <= pc_next;
			pc_load_reg <= pc_load_next;
			discard_reg <= discard_next;
			data_reg <= data_next;
			addr_reg <= addr_next;
			rd_en_reg <= rd_en_next;
			wr_en_reg <= wr_en_next;
			wdata_reg <= wdata_next;
		end
	end

	// ********************************
	// outputs
	// ********************************
	// no status flag port: none of these operations touch flags
	assign q_phase = q_reg;
	assign pc = pc_reg;
	assign pc_load = pc_load_reg;
	assign discard_fetch = discard_reg;
	assign exec_nop = (op_reg == OP_NOP);
	assign decode_hit = (op_reg != OP_NONE) && (op_reg != OP_NOP);
	assign dmem_addr = addr_reg;
	assign dmem_rd_en = rd_en_reg;
	assign dmem_wr_en = wr_en_reg;
	assign dmem_wdata = wdata_reg;
endmodule

// ==== shared/rbbo_defines.vh ====
// Contract
// - jump target is incremented pc plus twice offset
// - jump opcode is 1101, zero, 11-bit offset
// - jump takes two cycles, second is nop
// - opcode 1000 sets bit b of register f
// - access bit picks quick bank or pointer bank
// - extended set, a zero, f<=95 uses indexed offset
`ifndef RBBO_DEFINES_VH
`define RBBO_DEFINES_VH

// ********************************
// instruction cycle phases
// ********************************
`define RBBO_Q1 2'h0
`define RBBO_Q2 2'h1
`define RBBO_Q3 2'h2
`define RBBO_Q4 2'h3

// ********************************
// opcode fields
// ********************************
`define RBBO_OPC_HI 15
`define RBBO_OPC_LO 12
`define RBBO_OPC_JUMP 4'hd
`define RBBO_OPC_BSET 4'h8
`define RBBO_OPC_SKIPCLR 4'hb
`define RBBO_OPC_SKIPSET 4'ha
`define RBBO_JUMP_ZBIT 11
`define RBBO_JUMP_OFF_HI 10
`define RBBO_BIT_HI 11
`define RBBO_BIT_LO 9
`define RBBO_ACC_BIT 8
`define RBBO_FILE_HI 7
`define RBBO_FILE_LO 0

// ********************************
// data addressing
// ********************************
`define RBBO_INDEX_MAX 8'h5f
`define RBBO_ACCESS_SPLIT 8'h60
`define RBBO_ACCESS_HI_BANK 4'hf
`define RBBO_ACCESS_LO_BANK 4'h0

// ********************************
// skip and pc
// ********************************
`define RBBO_SKIP_ONE 2'h1
`define RBBO_SKIP_TWO 2'h2
`define RBBO_NOP_NONE 2'h0
`define RBBO_PC_STEP 2'h2
`define RBBO_PC_RESET 16'h0000

`endif

// ==== verilog/rbbo_bank_addr.v ====
`timescale 1ns/1ns
`include "rbbo_defines.vh"

module rbbo_bank_addr
(
	file_addr,
	access_bit,
	bank_select_pointer,
	ext_instr_en,
	index_base,
	data_addr,
	indexed_mode
);
	input wire [7:0] file_addr;
	input wire access_bit;
	input wire [3:0] bank_select_pointer;
	input wire ext_instr_en;
	input wire [11:0] index_base;
	output reg [11:0] data_addr;
	output wire indexed_mode;

	// ********************************
	// bank selection
	// ********************************
	assign indexed_mode = ext_instr_en & ~access_bit & (file_addr <= `RBBO_INDEX_MAX);

	always @*
	begin
		if (indexed_mode)
			data_addr = index_base + {4'h0, file_addr};
		else if (access_bit)
			data_addr = {bank_select_pointer, file_addr};
		else if (file_addr < `RBBO_ACCESS_SPLIT)
			data_addr = {`RBBO_ACCESS_LO_BANK, file_addr};
		else
			data_addr = {`RBBO_ACCESS_HI_BANK, file_addr};
	end
endmodule

// ==== tb/rbbo_core_properties.sv ====
`timescale 1ns/1ns
// ****
// decode and jump checker
// ****
module rbbo_core_chk
#(
	parameter PC_W = 21
)
(
	input wire mclk,
	input wire sys_rst,
	input wire [15:0] instr_word,
	input wire next_two_word,
	input wire [3:0] bank_select_pointer,
	input wire ext_instr_en,
	input wire [11:0] index_base,
	input wire [7:0] dmem_rdata,
	input wire [1:0] q_phase,
	input wire [PC_W-1:0] pc,
	input wire pc_load,
	input wire discard_fetch,
	input wire exec_nop,
	input wire decode_hit,
	input wire [11:0] dmem_addr,
	input wire dmem_rd_en,
	input wire dmem_wr_en,
	input wire [7:0] dmem_wdata
);
	// ****
	// own count of forced nops
	// ****
	reg [1:0] pend = 2'h0;
	reg [3:0] tst_op = 4'h0;
	reg tst_v = 1'b0;
	reg skip_q = 1'b0;
	// exec_nop lags one cycle, so decode slots come from this count instead
	wire go = q_phase == 2'h0 && pend == 2'h0;
	wire jmp = go && instr_word[15:11] == 5'h1a;
	wire tst = go && instr_word[15:13] == 3'h5;
	wire mem = tst || (go && instr_word[15:12] == 4'h8);
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			pend <= 2'h0;
			tst_v <= 1'b0;
			skip_q <= 1'b0;
		end
		else
		begin
			if (q_phase == 2'h0)
			begin
				pend <= (pend != 2'h0) ? pend - 2'h1 : {1'b0, jmp};
				tst_v <= tst;
				tst_op <= instr_word[12:9];
			end
			if (q_phase == 2'h2)
				skip_q <= tst_v && dmem_rdata[tst_op[2:0]] != tst_op[3];
			if (q_phase == 2'h3 && skip_q)
				pend <= 2'h1 + {1'b0, next_two_word};
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	AST_JUMP_PC: assert property (
		jmp |-> ##4 pc == PC_W'($past(pc, 4) + 2 +
		{{(PC_W-11){$past(instr_word[10], 4)}}, $past(instr_word[10:0], 4), 1'b0}))
		else $error("jump target wrong");
	AST_JUMP_ENC: assert property (
		go && instr_word[15:11] == 5'h1b |-> ##4 !pc_load && !discard_fetch)
		else $error("bad jump form acted on");
	AST_JUMP_NOP: assert property (
		jmp |-> ##4 (pc_load && discard_fetch && !exec_nop) ##1 exec_nop [*4] ##0 pc == PC_W'($past(pc, 4) + 2))
		else $error("jump nop cycle wrong");
	AST_BSET_DATA: assert property (
		go && instr_word[15:12] == 4'h8 |-> ##4 dmem_wr_en &&
		dmem_wdata == ($past(dmem_rdata, 2) | (8'h01 << $past(instr_word[11:9], 4))))
		else $error("bit set write wrong");
	AST_BANK_PTR: assert property (
		mem && instr_word[8] |-> ##2 dmem_rd_en &&
		dmem_addr == {$past(bank_select_pointer), $past(instr_word[7:0], 2)})
		else $error("pointer bank address wrong");
	AST_ACCESS: assert property (
		mem && !instr_word[8] && !ext_instr_en |-> ##2
		dmem_addr == {{4{$past(instr_word[7:0], 2) > 8'h5f}}, $past(instr_word[7:0], 2)})
		else $error("quick bank address wrong");
	AST_INDEXED: assert property (
		mem && !instr_word[8] && ext_instr_en && instr_word[7:0] <= 8'h5f |-> ##2
		dmem_addr == $past(index_base, 2) + $past(instr_word[7:0], 2))
		else $error("indexed address wrong");
	AST_SKIP_NOT: assert property (
		tst ##2 dmem_rdata[$past(instr_word[11:9], 2)] == $past(instr_word[12], 2)
		|-> ##2 (!discard_fetch && !dmem_wr_en) ##1 !exec_nop)
		else $error("skip taken wrongly");
	AST_SKIP_TAKEN: assert property (
		tst ##2 dmem_rdata[$past(instr_word[11:9], 2)] != $past(instr_word[12], 2)
		|-> ##2 (discard_fetch && !exec_nop) ##1 exec_nop [*4] ##1 exec_nop == $past(next_two_word, 6))
		else $error("skip not taken or length wrong");
	AST_DECODE_HIT: assert property (
		q_phase == 2'h0 |-> ##1 decode_hit == $past(jmp || mem) && exec_nop == $past(!go))
		else $error("decode slot wrong");
endmodule

bind rbbo_core rbbo_core_chk #(.PC_W(PC_W)) u_rbbo_core_chk (.mclk(mclk), .sys_rst(sys_rst),
	.instr_word(instr_word), .next_two_word(next_two_word), .bank_select_pointer(bank_select_pointer),
	.ext_instr_en(ext_instr_en), .index_base(index_base), .dmem_rdata(dmem_rdata), .q_phase(q_phase),
	.pc(pc), .pc_load(pc_load), .discard_fetch(discard_fetch), .exec_nop(exec_nop), .decode_hit(decode_hit),
	.dmem_addr(dmem_addr),
	.dmem_rd_en(dmem_rd_en), .dmem_wr_en(dmem_wr_en), .dmem_wdata(dmem_wdata));

// ==== tb/rbbo_core_tb_top.sv ====
`timescale 1ns/1ns
module rbbo_core_tb_top;
	localparam PC_W = 16;
	localparam [127:0] CORNERS = 128'hd3ff_d400_d800_8e5f_8060_d000_d7ff_b2a5;
	localparam [19:0] TOPS = 20'hd_8ba1;
	reg mclk = 1'b0;
	reg sys_rst = 1'b1;
	reg [15:0] instr_word = 16'h0000;
	reg next_two_word = 1'b0;
	reg [3:0] bank_select_pointer = 4'h0;
	reg ext_instr_en = 1'b0;
	reg [11:0] index_base = 12'h000;
	reg [7:0] dmem_rdata = 8'h00;
	wire [1:0] q_phase;
	wire [PC_W-1:0] pc;
	wire pc_load, discard_fetch, exec_nop, decode_hit, dmem_rd_en, dmem_wr_en;
	wire [11:0] dmem_addr;
	wire [7:0] dmem_wdata;
	integer fails = 0;
	integer tests_run = 0;
	integer i;
	integer nops = 0;
	reg [15:0] w;
	always #2 mclk = ~mclk;
	rbbo_core #(.PC_W(PC_W)) u_rbbo_core (.mclk(mclk), .sys_rst(sys_rst), .instr_word(instr_word),
		.next_two_word(next_two_word), .bank_select_pointer(bank_select_pointer), .ext_instr_en(ext_instr_en),
		.index_base(index_base), .dmem_rdata(dmem_rdata), .q_phase(q_phase), .pc(pc), .pc_load(pc_load),
		.discard_fetch(discard_fetch), .exec_nop(exec_nop), .decode_hit(decode_hit), .dmem_addr(dmem_addr),
		.dmem_rd_en(dmem_rd_en), .dmem_wr_en(dmem_wr_en), .dmem_wdata(dmem_wdata));
	// ****
	// helpers
	// ****
	task chk(input [63:0] seen, input [63:0] exp, input string name);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp)
			begin
				fails = fails + 1;
				$display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	function [11:0] exp_addr(input [15:0] op);
		begin
			if (op[8])
				exp_addr = {bank_select_pointer, op[7:0]};
			else if (ext_instr_en && op[7:0] <= 8'h5f)
				exp_addr = index_base + op[7:0];
			else
				exp_addr = {{4{op[7:0] > 8'h5f}}, op[7:0]};
		end
	endfunction
	task conclude;
		begin
			$display("tests_run %0d fails %0d", tests_run, fails);
			if (fails == 0 && tests_run > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// one instruction cycle, entered at the falling edge inside q1
	task run(input [15:0] op);
		reg nop, bset, tst, jump, skip;
		reg [7:0] rd;
		reg [PC_W-1:0] pc_exp;
		begin
			instr_word = op;
			next_two_word = $urandom;
			bank_select_pointer = $urandom;
			ext_instr_en = $urandom;
			index_base = $urandom;
			rd = $urandom;
			dmem_rdata = rd;
			nop = nops > 0;
			bset = !nop && op[15:12] == 4'h8;
			tst = !nop && op[15:13] == 3'h5;
			jump = !nop && op[15:11] == 5'h1a;
			pc_exp = pc + 2;
			if (jump)
				pc_exp = pc + 2 + {{(PC_W-12){op[10]}}, op[10:0], 1'b0};
			repeat (2) @(negedge mclk);
			// exec_nop and decode_hit follow the op taken at the end of q1, so look in q3
			chk(exec_nop, nop, "exec_nop");
			chk(decode_hit, jump || bset || tst, "decode_hit");
			if (bset || tst)
				chk({dmem_rd_en, dmem_addr}, {1'b1, exp_addr(op)}, "dmem_addr");
			else
				chk(dmem_rd_en, 0, "dmem_rd_en");
			repeat (2) @(negedge mclk);
			skip = tst && (rd[op[11:9]] != op[12]);
			chk(pc, pc_exp, "pc");
			chk({pc_load, dmem_wr_en}, {jump, bset}, "strobes");
			if (bset)
				chk(dmem_wdata, rd | (8'h01 << op[11:9]), "dmem_wdata");
			chk(discard_fetch, jump || skip, "discard_fetch");
			nops = nop ? nops - 1 : jump ? 1 : skip ? 1 + next_two_word : 0;
		end
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		i = $urandom(21);
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		chk({q_phase, pc, pc_load, discard_fetch, exec_nop, decode_hit, dmem_rd_en, dmem_wr_en, dmem_addr},
			0, "reset");
		sys_rst = 1'b0;
		// back-to-back jumps: second falls in the nop cycle
		for (i = 0; i < 8; i = i + 1)
			run(CORNERS[127 - 16 * i -: 16]);
		for (i = 0; i < 400; i = i + 1)
		begin
			w = $urandom;
			w[15:12] = TOPS[4 * ($urandom % 5) +: 4];
			run(w);
		end
		conclude;
	end
	// 408 cycles of 16 ns need about 6.5 us; generous margin
	initial
	begin
		#20000;
		fails = fails + 1;
		conclude;
	end
endmodule
